// ==== design/scan_feed_params.svh ====
// Purpose: constants of the scanner and document_feeder sequencer
// Assumes: 50 MHz system clock
// Notes:   times are kept in their own unit; cycle counts derive from them
//
// Behaviour
// - Colour scan lights red, green, blue in turn; captures recombined per line.
// - Monochrome lights all three sources together; one exposure per line.
// - Colour moves the carriage three times slower than monochrome.
// - Lower resolution moves the carriage faster; 300 ppi faster than 600 ppi.
// - Copy jobs capture at 300 ppi; scan jobs use the selected resolution.
// - Each pixel leaves as three 8-bit components, 24 bits in all.
// - Power-on drives motor right and left; no encoder motion gives error 12.
// - Slow left move until stall finds side stop; else default origin.
// - White target response checked for minimum and maximum; failure gives error 14.
// - Optical search for origin features; not found gives error 6.
// - Calibration: broad analog gain first, then per-pixel digital black; the white pass only marks defects.
// - Defective front-side pixels marked at calibration and replaced from a neighbour.
// - Recalibrate only when the requested mode differs from the calibrated one.
// - Flatbed: light, move right for requested lines, return left home.
// - Job start tests paper present: feeder scan with parked carriage, else flatbed.
// - Feeder is inhibited while its cover is open.
// - Lift plate down in standby; raised to pick roller on job start.
// - Page capture begins when top-of-form sees the leading edge.
// - Pick and feed repeat while paper is present in the tray.
// - After the last trailing edge, eject and lower the lift plate.
// - Duplex captures back and front sides in one pass together.
// - Page missing top-of-form: pulse motor, cycle lift; three tries then mispick.
// - Trailing edge not seen within 381 mm page time declares a jam.
// - On jam stop feeding, lower the lift plate and flag the jam.
`ifndef SCAN_FEED_PARAMS_SVH
`define SCAN_FEED_PARAMS_SVH
`define CLK_HZ       50000000
`define LINE_PIX     16
`define MOTOR_TEST_MS 20
`define STALL_MS     5
`define WALL_MS      2000
`define ORIGIN_MS    500
`define PICK_MS      1000
`define PULSE_MS     50
`define EJECT_MS     300
`define LOWER_MS     300
`define LINE_US      100
`define PAGE_MM      381
`define FEED_MM_S    100
`define MS_CYC(t)    ((t) * (`CLK_HZ / 1000))
`define DARK_LIM     8'h20
`define WHITE_LO     8'h40
`define WHITE_HI     8'hF0
`define CAL_TGT      8'hC0
`define GAIN_RST     8'h80
`define GAIN_STEP    8'h08
`define GAIN_TRIES   4'h8
`define DEFECT_MIN   8'h30
`define PICK_TRIES   2'h3
`define ERR_MOTOR    8'h0C
`define ERR_LED      8'h0E
`define ERR_HOME     8'h06
`endif

// ==== design/scan_pkg.sv ====
// Purpose: types shared by the sequencer and its users
// Assumes: nothing beyond the constants header
// Notes:   res code 0 = 300 ppi, 1 = 600 ppi, 2 = 1200 ppi
package scan_pkg;
	typedef enum logic [4:0] {S_MT_R, S_MT_L, S_WALL, S_LEDCHK, S_ORIGIN, S_CAL_A, S_CAL_B, S_CAL_W,
		S_IDLE, S_DISP, S_FB_SCAN, S_FB_RET, S_PARK, S_LIFT, S_PICK, S_RETRY, S_FEED, S_EJECT,
		S_LOWER, S_JAM} main_t;
	typedef enum logic [1:0] {C_IDLE, C_EXP, C_DRAIN} cap_t;
	typedef struct packed {
		logic        color;
		logic        copy;
		logic        duplex;
		logic [1:0]  res;
		logic [15:0] lines;
	} job_t;
	typedef struct packed {
		logic       color;
		logic [1:0] res;
	} mode_t;
	typedef struct packed {
		logic encoder;
		logic paper;
		logic tof;
		logic door;
		logic stack;
	} sens_t;
	typedef struct packed {
		logic       valid;
		logic [7:0] front;
		logic [7:0] back;
	} line_in_t;
	typedef struct packed {
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
	} pixel_t;
	typedef struct packed {
		logic   side;
		pixel_t pix;
	} out_word_t;
	typedef struct packed {
		logic       motor_run;
		logic       motor_dir;
		logic       motor_slow;
		logic       lift_up;
		logic       lift_dn;
		logic       pick_run;
		logic       feed_run;
		logic       eject_run;
		logic [2:0] led;
	} act_t;
endpackage

// ==== design/scanner_feeder_sequencer.sv ====
// Purpose: carriage, illumination, self-test and document_feeder sequencing
// Assumes: pixels of the contact_line_sensor arrive on the system clock after the lights settle
// Notes:   FIFO depth must be a power of two
`timescale 1ns/1ps
`include "scan_feed_params.svh"

module pixel_fifo #(
	parameter int W = 25,
	parameter int D = 8
) (
	input  wire logic         i_clock,
	input  wire logic         i_rst_b,
	input  wire logic         i_in_valid,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_in_ready,
	output logic              o_out_valid,
	output logic [W-1:0]      o_out_data,
	input  wire logic         i_out_ready
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
		logic                ov;
		logic [W-1:0]        od;
	} fst_t;
	fst_t q;
	fst_t d;
	logic push;
	logic pop;

	assign o_in_ready  = q.cnt != (AW+1)'(D);
	assign o_out_valid = q.ov;
	assign o_out_data  = q.od;
	always_comb begin
		d    = q;
		push = i_in_valid && (q.cnt != (AW+1)'(D));
		pop  = (!q.ov || i_out_ready) && (q.cnt != '0);
		if (push) begin
			d.mem[q.wp] = i_in_data;
			d.wp        = q.wp + 1'b1;
		end
		if (pop) begin
			d.od = q.mem[q.rp];
			d.ov = 1'b1;
			d.rp = q.rp + 1'b1;
		end else if (i_out_ready) begin
			d.ov = 1'b0;
		end
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////

module scanner_feeder_sequencer #(
	parameter logic [31:0] MT_CYC   = 32'(`MS_CYC(`MOTOR_TEST_MS)),
	parameter logic [31:0] STALL_CYC = 32'(`MS_CYC(`STALL_MS)),
	parameter logic [31:0] WALL_CYC = 32'(`MS_CYC(`WALL_MS)),
	parameter logic [31:0] ORG_CYC  = 32'(`MS_CYC(`ORIGIN_MS)),
	parameter logic [31:0] PICK_CYC = 32'(`MS_CYC(`PICK_MS)),
	parameter logic [31:0] PULSE_CYC = 32'(`MS_CYC(`PULSE_MS)),
	parameter logic [31:0] EJECT_CYC = 32'(`MS_CYC(`EJECT_MS)),
	parameter logic [31:0] LWR_CYC  = 32'(`MS_CYC(`LOWER_MS)),
	parameter logic [31:0] LINE_CYC = 32'(`LINE_US * (`CLK_HZ / 1000000)),
	parameter logic [31:0] JAM_CYC  = 32'(`PAGE_MM * (`CLK_HZ / `FEED_MM_S))
) (
	input  wire logic                  i_clock,
	input  wire logic                  i_rst_b,
	input  wire logic                  i_job_start,
	input  wire scan_pkg::job_t        i_job,
	input  wire scan_pkg::sens_t       i_sens,
	input  wire scan_pkg::line_in_t    i_pix,
	input  wire logic                  i_pix_ready,
	output logic                       o_pix_valid,
	output scan_pkg::out_word_t        o_pix,
	output scan_pkg::act_t             o_act,
	output logic [31:0]                o_line_period,
	output logic [7:0]                 o_analog_gain,
	output logic [7:0]                 o_error_code,
	output logic                       o_ready,
	output logic                       o_jam,
	output logic                       o_mispick,
	output logic                       o_origin_default
);
	localparam int LP = `LINE_PIX;
	localparam int IW = $clog2(LP);
	typedef struct packed {
		logic [4:0]                   s1;
		logic [4:0]                   s2;
		logic [4:0]                   s3;
		logic [4:0]                   f;
		logic                         enc_prev;
		scan_pkg::main_t              st;
		scan_pkg::cap_t               cst;
		logic [31:0]                  tmr;
		logic [31:0]                  ltmr;
		logic [31:0]                  stall;
		logic [15:0]                  lines;
		logic [1:0]                   tries;
		logic [3:0]                   gtry;
		logic                         moved;
		logic                         pend;
		logic                         issued;
		scan_pkg::job_t               job;
		scan_pkg::mode_t              cal;
		logic [1:0]                   col;
		logic [IW-1:0]                idx;
		logic                         side;
		logic                         ccol;
		logic                         raw;
		logic                         dark;
		logic                         calb;
		logic                         calw;
		logic [7:0]                   mn;
		logic [7:0]                   mx;
		logic [1:0][2:0][LP-1:0][7:0] mem;
		logic [LP-1:0][7:0]           blk;
		logic [LP-1:0]                bad;
		scan_pkg::act_t               act;
		logic [31:0]                  per;
		logic [7:0]                   gain;
		logic [7:0]                   err;
		logic                         rdy;
		logic                         jam;
		logic                         mispick;
		logic                         odef;
	} st_t;
	st_t                 q;
	st_t                 d;
	scan_pkg::sens_t     fs;
	logic                enc_edge;
	logic                stalled;
	logic                cdone;
	logic                f_in_valid;
	logic                f_in_ready;
	logic [IW-1:0]       nb;
	logic [2:0][7:0]     comp;
	scan_pkg::out_word_t f_word;
	logic [31:0]         base;

	function automatic st_t cap_go(st_t s, logic ccol, logic raw, logic dark, logic cb, logic cw);
		st_t r;
		r        = s;
		r.cst    = scan_pkg::C_EXP;
		r.col    = 2'h0;
		r.idx    = '0;
		r.side   = 1'b0;
		r.mn     = 8'hFF;
		r.mx     = 8'h00;
		r.ccol   = ccol;
		r.raw    = raw;
		r.dark   = dark;
		r.calb   = cb;
		r.calw   = cw;
		r.issued = 1'b1;
		r.ltmr   = '0;
		return r;
	endfunction

	assign fs       = scan_pkg::sens_t'(q.f);
	assign enc_edge = fs.encoder != q.enc_prev;
	assign stalled  = q.stall >= STALL_CYC;
	assign cdone    = q.issued && (q.cst == scan_pkg::C_IDLE);
	assign base     = LINE_CYC << q.job.res;

	////////////////////////////////////////////////////////////////////////////
	// Drain path: front-side black subtraction and defect replacement
	assign nb = (q.idx == '0) ? IW'(1) : q.idx - 1'b1;
	genvar gc;
	generate
		for (gc = 0; gc < 3; gc++) begin : g_col
			logic [7:0] pv;
			logic [7:0] bv;
			assign pv = (!q.side && q.bad[q.idx]) ? q.mem[0][gc][nb] : q.mem[q.side][gc][q.idx];
			assign bv = q.side ? 8'h00 : (q.bad[q.idx] ? q.blk[nb] : q.blk[q.idx]);
			assign comp[gc] = (pv > bv) ? pv - bv : 8'h00;
		end
	endgenerate
	assign f_word     = '{side: q.side, pix: '{r: comp[0], g: comp[1], b: comp[2]}};
	assign f_in_valid = q.cst == scan_pkg::C_DRAIN;

	pixel_fifo #(.W($bits(scan_pkg::out_word_t)), .D(8)) u_fifo (
		.i_clock     (i_clock),
		.i_rst_b     (i_rst_b),
		.i_in_valid  (f_in_valid),
		.i_in_data   (f_word),
		.o_in_ready  (f_in_ready),
		.o_out_valid (o_pix_valid),
		.o_out_data  (o_pix),
		.i_out_ready (i_pix_ready)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d          = q;
		d.s1       = i_sens;
		d.s2       = q.s1;
		d.s3       = q.s2;
		d.f        = (q.s2 & q.s3) | (q.f & (q.s2 ^ q.s3));
		d.enc_prev = fs.encoder;
		d.stall    = enc_edge ? '0 : (stalled ? q.stall : q.stall + 32'h1);
		d.tmr      = q.tmr + 32'h1;
		d.ltmr     = q.ltmr + 32'h1;
		if (cdone) begin
			d.issued = 1'b0;
		end
		// Capture engine
		case (q.cst)
			scan_pkg::C_EXP: begin
				if (i_pix.valid) begin
					for (int c = 0; c < 3; c++) begin
						if (!q.ccol || c == int'(q.col)) begin
							d.mem[0][c][q.idx] = i_pix.front;
							d.mem[1][c][q.idx] = i_pix.back;
						end
					end
					d.mn = (i_pix.front < q.mn) ? i_pix.front : q.mn;
					d.mx = (i_pix.front > q.mx) ? i_pix.front : q.mx;
					if (q.calb) begin
						d.blk[q.idx] = i_pix.front;
					end
					if (q.calw) begin
						d.bad[q.idx] = i_pix.front < `DEFECT_MIN;
					end
					d.idx = q.idx + 1'b1;
					if (q.idx == IW'(LP - 1)) begin
						if (q.ccol && q.col != 2'h2) begin
							d.col = q.col + 2'h1;
						end else begin
							d.cst = q.raw ? scan_pkg::C_IDLE : scan_pkg::C_DRAIN;
						end
					end
				end
			end
			scan_pkg::C_DRAIN: begin
				if (f_in_ready) begin
					d.idx = q.idx + 1'b1;
					if (q.idx == IW'(LP - 1)) begin
						if (q.job.duplex && !q.side) begin
							d.side = 1'b1;
						end else begin
							d.cst = scan_pkg::C_IDLE;
						end
					end
				end
			end
			default: begin
			end
		endcase
		// Sequencer
		case (q.st)
			scan_pkg::S_MT_R, scan_pkg::S_MT_L: begin
				d.moved = q.moved | enc_edge;
				if (q.tmr >= MT_CYC) begin
					d.tmr = '0;
					if (q.st == scan_pkg::S_MT_R) begin
						d.st = scan_pkg::S_MT_L;
					end else if (!d.moved) begin
						d.err = `ERR_MOTOR;
						d.st  = scan_pkg::S_IDLE;
					end else begin
						d.st = scan_pkg::S_WALL;
					end
				end
			end
			scan_pkg::S_WALL: begin
				if (stalled && q.tmr >= STALL_CYC) begin
					d.st  = scan_pkg::S_LEDCHK;
					d.tmr = '0;
				end else if (q.tmr >= WALL_CYC) begin
					d.odef = 1'b1;
					d.st   = scan_pkg::S_LEDCHK;
					d.tmr  = '0;
				end
			end
			scan_pkg::S_LEDCHK: begin
				if (!q.issued) begin
					d = cap_go(d, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
				end else if (cdone) begin
					d.tmr = '0;
					if (q.mn < `WHITE_LO || q.mx > `WHITE_HI) begin
						d.err = `ERR_LED;
						d.st  = scan_pkg::S_IDLE;
					end else begin
						d.st = scan_pkg::S_ORIGIN;
					end
				end
			end
			scan_pkg::S_ORIGIN: begin
				if (cdone && q.mn <= `DARK_LIM) begin
					d.st   = scan_pkg::S_CAL_A;
					d.gain = `GAIN_RST;
				end else if (q.tmr >= ORG_CYC && (cdone || !q.issued)) begin
					d.err  = `ERR_HOME;
					d.st   = scan_pkg::S_CAL_A;
					d.gain = `GAIN_RST;
				end else if (!q.issued || cdone) begin
					d = cap_go(d, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
				end
			end
			scan_pkg::S_CAL_A: begin
				if (!q.issued) begin
					d = cap_go(d, q.job.color, 1'b1, 1'b0, 1'b0, 1'b0);
				end else if (cdone) begin
					if (q.mx < `CAL_TGT && q.gtry != `GAIN_TRIES) begin
						d.gain = q.gain + `GAIN_STEP;
						d.gtry = q.gtry + 4'h1;
					end else begin
						d.gtry = 4'h0;
						d.st   = scan_pkg::S_CAL_B;
					end
				end
			end
			scan_pkg::S_CAL_B: begin
				if (!q.issued) begin
					d = cap_go(d, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
				end else if (cdone) begin
					d.st = scan_pkg::S_CAL_W;
				end
			end
			scan_pkg::S_CAL_W: begin
				if (!q.issued) begin
					d = cap_go(d, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
				end else if (cdone) begin
					d.cal  = '{color: q.job.color, res: q.job.res};
					d.pend = 1'b0;
					d.st   = q.pend ? scan_pkg::S_DISP : scan_pkg::S_IDLE;
				end
			end
			scan_pkg::S_IDLE: begin
				if (i_job_start) begin
					d.job     = i_job;
					d.job.res = i_job.copy ? 2'h0 : i_job.res;
					d.jam     = 1'b0;
					d.mispick = 1'b0;
					if (d.job.color != q.cal.color || d.job.res != q.cal.res) begin
						d.st   = scan_pkg::S_CAL_A;
						d.gain = `GAIN_RST;
						d.pend = 1'b1;
					end else begin
						d.st = scan_pkg::S_DISP;
					end
				end
			end
			scan_pkg::S_DISP: begin
				d.tmr   = '0;
				d.lines = 16'h0000;
				d.tries = 2'h0;
				d.st    = (fs.paper && !fs.door) ? scan_pkg::S_PARK : scan_pkg::S_FB_SCAN;
			end
			scan_pkg::S_FB_SCAN, scan_pkg::S_FEED: begin
				if (q.st == scan_pkg::S_FEED && q.tmr >= JAM_CYC) begin
					d.jam = 1'b1;
					d.st  = scan_pkg::S_JAM;
					d.tmr = '0;
				end else if (q.st == scan_pkg::S_FEED && !fs.tof) begin
					d.st  = scan_pkg::S_EJECT;
					d.tmr = '0;
				end else if (q.st == scan_pkg::S_FB_SCAN && q.lines == q.job.lines && q.cst == scan_pkg::C_IDLE) begin
					d.st = scan_pkg::S_FB_RET;
				end else if (q.cst == scan_pkg::C_IDLE && q.ltmr >= q.per - 32'h1 &&
						(q.st == scan_pkg::S_FEED || q.lines != q.job.lines)) begin
					d       = cap_go(d, q.job.color, 1'b0, 1'b0, 1'b0, 1'b0);
					d.lines = q.lines + 16'h0001;
				end
			end
			scan_pkg::S_FB_RET, scan_pkg::S_PARK: begin
				if (stalled && q.tmr >= STALL_CYC) begin
					d.st = (q.st == scan_pkg::S_PARK) ? scan_pkg::S_LIFT : scan_pkg::S_IDLE;
				end
			end
			scan_pkg::S_LIFT: begin
				if (fs.stack && !fs.door) begin
					d.st  = scan_pkg::S_PICK;
					d.tmr = '0;
				end
			end
			scan_pkg::S_PICK: begin
				if (fs.tof && !fs.door) begin
					d.st  = scan_pkg::S_FEED;
					d.tmr = '0;
					d.ltmr = q.per;
				end else if (q.tmr >= PICK_CYC) begin
					d.tries = q.tries + 2'h1;
					d.tmr   = '0;
					if (d.tries == `PICK_TRIES) begin
						d.mispick = 1'b1;
						d.st      = scan_pkg::S_LOWER;
					end else begin
						d.st = scan_pkg::S_RETRY;
					end
				end
			end
			scan_pkg::S_RETRY: begin
				if (q.tmr >= PULSE_CYC) begin
					d.st = scan_pkg::S_LIFT;
				end
			end
			scan_pkg::S_EJECT: begin
				if (q.tmr >= EJECT_CYC) begin
					d.tmr   = '0;
					d.tries = 2'h0;
					d.st    = fs.paper ? scan_pkg::S_PICK : scan_pkg::S_LOWER;
				end
			end
			scan_pkg::S_LOWER, scan_pkg::S_JAM: begin
				if (q.tmr >= LWR_CYC) begin
					d.st = scan_pkg::S_IDLE;
				end
			end
			default: begin
				d.st = scan_pkg::S_IDLE;
			end
		endcase
		// Registered ready and actuator outputs follow the next state; line period the current job
		d.per = q.job.color ? 32'(base * 32'h3) : base;
		d.rdy = d.st == scan_pkg::S_IDLE;
		d.act.motor_run = d.st inside {scan_pkg::S_MT_R, scan_pkg::S_MT_L, scan_pkg::S_WALL, scan_pkg::S_ORIGIN,
			scan_pkg::S_FB_SCAN, scan_pkg::S_FB_RET, scan_pkg::S_PARK};
		d.act.motor_dir  = d.st inside {scan_pkg::S_MT_R, scan_pkg::S_ORIGIN, scan_pkg::S_FB_SCAN};
		d.act.motor_slow = d.st == scan_pkg::S_WALL;
		d.act.lift_up   = !fs.door && (d.st inside {scan_pkg::S_LIFT, scan_pkg::S_PICK, scan_pkg::S_FEED,
			scan_pkg::S_EJECT});
		d.act.lift_dn   = !fs.door && (d.st inside {scan_pkg::S_RETRY, scan_pkg::S_LOWER, scan_pkg::S_JAM});
		d.act.pick_run  = !fs.door && (d.st inside {scan_pkg::S_PICK, scan_pkg::S_RETRY});
		d.act.feed_run  = !fs.door && (d.st inside {scan_pkg::S_FEED, scan_pkg::S_EJECT});
		d.act.eject_run = !fs.door && (d.st == scan_pkg::S_EJECT);
		if (d.cst != scan_pkg::C_EXP || d.dark) begin
			d.act.led = 3'h0;
		end else begin
			d.act.led = d.ccol ? 3'(3'h1 << d.col) : 3'h7;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_act            = q.act;
	assign o_line_period    = q.per;
	assign o_analog_gain    = q.gain;
	assign o_error_code     = q.err;
	assign o_ready          = q.rdy;
	assign o_jam            = q.jam;
	assign o_mispick        = q.mispick;
	assign o_origin_default = q.odef;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	motor_err_a: assert property ((q.st == scan_pkg::S_MT_L && q.tmr >= MT_CYC && !q.moved && !enc_edge)
		|=> (q.err == `ERR_MOTOR && q.st == scan_pkg::S_IDLE) ##1 q.err == `ERR_MOTOR) else $error("motor error");
	mono_led_a: assert property ((q.cst == scan_pkg::C_EXP && !q.ccol && !q.dark) |-> q.act.led == 3'h7)
		else $error("mono lights");
	color_led_a: assert property ((q.cst == scan_pkg::C_EXP && q.ccol && !q.dark)
		|-> ($onehot(q.act.led) && q.act.led[q.col])) else $error("colour light order");
	speed_ratio_a: assert property ($stable(q.job) && q.job.color |-> q.per == 32'(3 * (LINE_CYC << q.job.res)))
		else $error("carriage speed");
	copy_res_a: assert property ((q.st == scan_pkg::S_IDLE && i_job_start && i_job.copy)
		|=> q.job.res == 2'h0 ##1 q.per >= LINE_CYC) else $error("copy resolution");
	door_block_a: assert property (fs.door |=> !(q.act.lift_up || q.act.pick_run || q.act.feed_run
		|| q.act.eject_run)) else $error("feeder active with door open");
	standby_lift_a: assert property (q.st == scan_pkg::S_IDLE |-> !q.act.lift_up) else $error("lift up idle");
	tof_start_a: assert property ((q.st == scan_pkg::S_PICK && fs.tof && !fs.door) |=> q.st == scan_pkg::S_FEED)
		else $error("leading edge missed");
	mispick_a: assert property ((q.st == scan_pkg::S_PICK && q.tmr >= PICK_CYC && !fs.tof
		&& q.tries == 2'h2) |=> (q.mispick && q.st == scan_pkg::S_LOWER)) else $error("mispick");
	jam_stop_a: assert property ((q.st == scan_pkg::S_FEED && q.tmr >= JAM_CYC)
		|=> (q.jam && !q.act.feed_run && q.act.lift_dn == !$past(fs.door))) else $error("jam handling");
	flatbed_dir_a: assert property (q.st == scan_pkg::S_FB_SCAN |-> (q.act.motor_run && q.act.motor_dir))
		else $error("flatbed direction");

	page_fed_c: cover property (q.st == scan_pkg::S_FEED ##1 q.st == scan_pkg::S_EJECT);
	flatbed_done_c: cover property (q.st == scan_pkg::S_FB_RET ##1 q.st == scan_pkg::S_IDLE);
	jam_c: cover property ($rose(q.jam));
	pixel_out_c: cover property (o_pix_valid && i_pix_ready && q.job.color);
endmodule

// ==== verification/scan_far_side.sv ====
// Purpose: carriage, encoder, feeder, sensor and formatter model
// Assumes: carriage travel of 255 encoder steps
// Notes:   fault modes chosen by the bench
`timescale 1ns/1ps
module scan_far_side (
	input  wire logic               i_clock,
	input  wire scan_pkg::act_t     i_act,
	input  wire logic               i_enc_dead,
	input  wire logic [1:0]         i_tof_mode,
	input  wire logic               i_paper,
	input  wire logic               i_door,
	output scan_pkg::sens_t         o_sens,
	output scan_pkg::line_in_t      o_pix,
	output logic                    o_pix_ready
);
	logic [7:0]  pos = 8'h10;
	logic [11:0] tc  = 12'h000;
	logic [2:0]  ph  = 3'h0;
	logic        enc = 1'b0;
	logic        stk = 1'b0;
	logic        tof;
	// Encoder stalls at either end of travel
	always_ff @(posedge i_clock) begin
		ph  <= ph + 3'h1;
		stk <= i_act.lift_up | (stk & ~i_act.lift_dn);
		// One step per 4 cycles so the 3-stage pin filter sees every encoder edge
		if (ph[1:0] == 2'h0 && i_act.motor_run && !i_enc_dead && (i_act.motor_dir ? pos != 8'hFF : pos != 8'h00)) begin
			pos <= i_act.motor_dir ? pos + 8'h01 : pos - 8'h01;
			enc <= ~enc;
		end
		if (i_act.eject_run || i_act.lift_dn)
			tc <= 12'h000;
		else if ((i_act.pick_run || i_act.feed_run || tof) && tc != 12'hFFF)
			tc <= tc + 12'h001;
	end
	// Mode 1 never reaches the sensor, mode 2 never clears it
	assign tof         = i_tof_mode != 2'h1 && tc >= 12'h008 && (i_tof_mode == 2'h2 || tc < 12'h030);
	assign o_sens      = scan_pkg::sens_t'({enc, i_paper, tof, i_door, stk});
	assign o_pix.valid = ph[0];
	assign o_pix.front = (i_act.led != 3'h0) ? 8'hC0 : 8'h10;
	assign o_pix.back  = 8'hA0;
	assign o_pix_ready = ph != 3'h7;
endmodule

// ==== verification/scanner_feeder_sequencer_tb_top.sv ====
// Purpose: self-checking bench for the sequencer
// Assumes: shortened timing parameters
// Notes:   one task per scenario
`timescale 1ns/1ps
module scanner_feeder_sequencer_tb_top;
	logic clock = 1'b0, rst_b = 1'b0, job_start = 1'b0, enc_dead = 1'b0, paper = 1'b0, door = 1'b0;
	logic [1:0] tof_mode = 2'h0;
	scan_pkg::job_t job = '0;
	scan_pkg::sens_t sens;
	scan_pkg::line_in_t pix;
	scan_pkg::out_word_t o_pix;
	scan_pkg::out_word_t last;
	logic dup = 1'b0;
	localparam logic [31:0] MT_T = 32'h14, STALL_T = 32'h8, WALL_T = 32'hC8, ORG_T = 32'h190, PICK_T = 32'h32;
	localparam logic [31:0] PULSE_T = 32'h5, EJECT_T = 32'hA, LWR_T = 32'hA, LINE_T = 32'h3C, JAM_T = 32'h12C;
	scan_pkg::act_t o_act;
	logic pix_ready, o_pix_valid, o_ready, o_jam, o_mispick, o_origin_default, right;
	logic [31:0] o_line_period, per, p, words;
	logic [7:0] o_analog_gain, o_error_code, hist;
	int miscompares = 0, comparisons = 0, cyc = 0;
	always #10 clock = ~clock;
	scanner_feeder_sequencer #(.MT_CYC(MT_T), .STALL_CYC(STALL_T), .WALL_CYC(WALL_T), .ORG_CYC(ORG_T),
		.PICK_CYC(PICK_T), .PULSE_CYC(PULSE_T), .EJECT_CYC(EJECT_T), .LWR_CYC(LWR_T), .LINE_CYC(LINE_T),
		.JAM_CYC(JAM_T)) i_scanner_feeder_sequencer (
		.i_clock(clock), .i_rst_b(rst_b), .i_job_start(job_start), .i_job(job), .i_sens(sens), .i_pix(pix),
		.i_pix_ready(pix_ready), .o_pix_valid(o_pix_valid), .o_pix(o_pix), .o_act(o_act),
		.o_line_period(o_line_period), .o_analog_gain(o_analog_gain), .o_error_code(o_error_code),
		.o_ready(o_ready), .o_jam(o_jam), .o_mispick(o_mispick), .o_origin_default(o_origin_default));
	scan_far_side i_scan_far_side (.i_clock(clock), .i_act(o_act), .i_enc_dead(enc_dead), .i_tof_mode(tof_mode),
		.i_paper(paper), .i_door(door), .o_sens(sens), .o_pix(pix), .o_pix_ready(pix_ready));
	always @(posedge clock) begin
		cyc++;
		if (cyc == 100000) begin
			miscompares++;
			test_done();
		end
		if (job_start) begin
			hist  <= 8'h00;
			words <= 32'h0;
			right <= 1'b0;
		end else begin
			hist[o_act.led] <= 1'b1;
			words <= words + 32'(o_pix_valid & pix_ready);
			if (o_pix_valid & pix_ready)
				last <= o_pix;
			right <= right | (o_act.motor_run & o_act.motor_dir);
			if (o_act.motor_run & o_act.motor_dir)
				per <= o_line_period;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		#1;
		while (o_ready !== 1'b1 && n < 20000) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n >= 20000)
			chk(32'h0, 32'h1);
	endtask
	task automatic por(input logic dead);
		@(posedge clock);
		enc_dead <= dead;
		rst_b    <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		repeat (2) @(posedge clock);
		wait_rdy();
	endtask
	task automatic go(input logic c, input logic cp, input logic [1:0] r, input logic [15:0] n);
		// Let sensor changes pass the pin filter before dispatch
		repeat (5) @(posedge clock);
		job       <= '{c, cp, dup, r, n};
		job_start <= 1'b1;
		@(posedge clock);
		job_start <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	task automatic feed(input logic [1:0] m);
		@(posedge clock);
		tof_mode <= m;
		paper    <= 1'b1;
		go(1'b0, 1'b0, 2'h0, 16'h1);
		repeat (200) @(posedge clock);
		paper <= 1'b0;
		wait_rdy();
	endtask
	task automatic t_selftest;
		por(1'b1);
		chk(o_error_code, 8'h0C);
		por(1'b0);
		chk(o_error_code, 8'h06);
		chk(o_origin_default, 0);
		chk(o_analog_gain, 8'h80);
		$display("selftest done");
	endtask
	task automatic t_flat;
		go(1'b0, 1'b0, 2'h0, 16'h4);
		wait_rdy();
		p = per;
		chk(hist, 8'h81);
		chk(last, 32'h0B0B0B0);
		chk(words, 64);
		chk(right, 1);
		go(1'b1, 1'b0, 2'h0, 16'h2);
		wait_rdy();
		chk(per, 3 * p);
		chk(hist[1] & hist[2] & hist[4], 1);
		chk(words, 32);
		go(1'b0, 1'b0, 2'h1, 16'h2);
		wait_rdy();
		chk(per > p, 1);
		go(1'b0, 1'b1, 2'h2, 16'h2);
		wait_rdy();
		chk(per, p);
		dup = 1'b1;
		go(1'b0, 1'b0, 2'h0, 16'h1);
		wait_rdy();
		dup = 1'b0;
		chk(words, 32);
		chk(last, 32'h1A0A0A0);
		$display("flatbed done");
	endtask
	task automatic t_feeder;
		feed(2'h0);
		chk(right, 0);
		chk(o_jam | o_mispick, 0);
		chk(words != 0, 1);
		chk(words > 16, 1);
		feed(2'h2);
		chk(o_jam, 1);
		chk(o_act.lift_up, 0);
		feed(2'h1);
		chk(o_mispick, 1);
		chk(o_jam, 0);
		$display("feeder done");
	endtask
	task automatic t_door;
		@(posedge clock);
		tof_mode <= 2'h0;
		door     <= 1'b1;
		paper    <= 1'b1;
		go(1'b0, 1'b0, 2'h0, 16'h1);
		wait_rdy();
		chk(right, 1);
		chk(words, 16);
		$display("door done");
	endtask
	task automatic test_done;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		t_selftest();
		t_flat();
		t_feeder();
		t_door();
		test_done();
	end
endmodule
